// ==== rtl/bist_loop_pkg.sv ====
// Package holding the register map, field layout, timing counts and carrier types of the block.
package bist_loop_pkg;

  // Printed register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_SELF_TEST_CONTROL = 8'h16;
  localparam logic [7:0] IDX_SECONDARY_STATUS = 8'h17;
  localparam logic [11:0] ADDR_SELF_TEST_CONTROL = {2'h0, IDX_SELF_TEST_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_SECONDARY_STATUS = {2'h0, IDX_SECONDARY_STATUS, 2'h0};

  // Control register field positions.
  localparam int CTL_WRAP_MODE = 15;
  localparam int CTL_RANDOM_PAYLOAD = 14;
  localparam int CTL_SHORT_FRAME = 13;
  localparam int CTL_GEN_ENABLE = 12;
  localparam int CTL_REV_FWD = 7;
  localparam int CTL_MII_FWD = 6;
  localparam int CTL_LOOP_HI = 5;
  localparam int CTL_LOOP_LO = 2;
  localparam int CTL_CODING_HI = 1;
  localparam int CTL_CODING_LO = 0;
  localparam logic [15:0] CTL_WRITABLE_MASK = 16'hF0FF;
  localparam logic [15:0] CTL_RESET = 16'h0000;

  // Status register field positions.
  localparam int STS_LOCKED = 11;
  localparam int STS_LOCK_DROPPED = 10;
  localparam int STS_GEN_ACTIVE = 9;
  localparam int STS_LEGACY_MASTER = 8;
  localparam int STS_LEGACY_SLAVE = 7;
  localparam int STS_CORE_POWER = 6;

  // One-hot loopback select codes.
  localparam logic [3:0] LOOP_REVERSE = 4'h8;
  localparam logic [3:0] LOOP_EXTERNAL = 4'h4;
  localparam logic [3:0] LOOP_ANALOG = 4'h2;
  localparam logic [3:0] LOOP_DIGITAL = 4'h1;

  // Coding-layer loop point codes at 100 Mb/s.
  localparam logic [1:0] CODING_AFTER_ENCODER = 2'h3;
  localparam logic [1:0] CODING_AFTER_SCRAMBLER = 2'h2;
  localparam logic [1:0] CODING_BEFORE_SCRAMBLER = 2'h1;

  // Frame lengths in bytes.
  localparam logic [10:0] SHORT_FRAME_BYTES = 11'd64;
  localparam logic [10:0] LONG_FRAME_BYTES = 11'd1518;
  localparam logic [7:0] CONSTANT_BYTE = 8'h55;

  // Pseudo-random sequence and checker thresholds.
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;
  localparam logic [3:0] LOCK_MATCH_COUNT = 4'h8;
  localparam logic [3:0] LOSS_MISMATCH_COUNT = 4'h4;
  localparam logic [15:0] COUNTER_MAX = 16'hFFFF;

  typedef enum logic [1:0] {GEN_IDLE, GEN_SEND, GEN_DONE} gen_state_e;

  // APB request and answer.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

  // Byte stream carrier.
  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic [7:0] data;
  } byte_beat_s;

endpackage

// ==== rtl/phy_bist_loopback_control.sv ====
// Self-test generator, checker and loopback control with its two APB-mapped registers.
//
// Notes on behaviour
// - In wrap mode, a counter at maximum emits one pulse and restarts from zero.
// - Random payload with generator on sends back-to-back pseudo-random frames.
// - Random payload with generator off keeps the checker running on receive.
// - Constant payload with generator on sends one frame; random logic off.
// - Frame length is 64 bytes when short frame is set, else 1518.
// - Generator enable bit switches the generator on and off.
// - Reserved fields ignore writes and read as zero.
// - Reverse loop forward bit settable only in reverse loop; gates receive to MAC.
// - Transmit forward bit settable only in MII loop; gates transmit to line.
// - Loopback select is one-hot: reverse, external, analog, digital.
// - At 100 Mb/s coding field picks after encoder, after scrambler, before scrambler.
// - At 1000 Mb/s coding bit 0 loops before gigabit signal processing.
// - Locked bit reads one while the checker is locked.
// - Lock-dropped flag latches on loss of lock and clears on read.
// - Generator active bit reads one while a frame is being generated.
// - Two bits report gigabit master and slave legacy encoding.
// - Power bit reads one in normal power, zero when down or asleep.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
module phy_bist_loopback_control (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire bist_loop_pkg::apb_req_s apb_req,
  output bist_loop_pkg::apb_rsp_s apb_rsp,
  input wire bist_loop_pkg::byte_beat_s rx_beat,
  output bist_loop_pkg::byte_beat_s gen_beat,
  input wire logic speed_100,
  input wire logic speed_1000,
  input wire logic legacy_master,
  input wire logic legacy_slave,
  input wire logic core_normal_power,
  output logic [3:0] loop_select,
  output logic coding_after_encoder,
  output logic coding_after_scrambler,
  output logic coding_before_scrambler,
  output logic gig_loop_before_dsp,
  output logic rx_to_mac_enable,
  output logic tx_to_line_enable,
  output logic counter_wrap_pulse,
  output logic [15:0] error_count,
  output logic [15:0] frame_count
);

  // Advances the pseudo-random register by eight bits and returns the new state.
  function automatic logic [14:0] prbs_step(input logic [14:0] state);
    logic [14:0] s;
    s = state;
    for (int i = 0; i < 8; i++) begin
      s = {s[13:0], s[14] ^ s[13]};
    end
    return s;
  endfunction

  // Counter step shared by the error and frame counters: wrap or saturate.
  function automatic logic [15:0] count_step(input logic [15:0] value, input logic wrap);
    logic [15:0] n;
    n = value;
    if (value == bist_loop_pkg::COUNTER_MAX) begin
      n = wrap ? 16'h0000 : value;
    end else begin
      n = value + 16'h0001;
    end
    return n;
  endfunction

  logic [15:0] ctl_q;
  logic [31:0] prdata_q;
  logic locked_q;
  logic lock_dropped_q;
  logic [3:0] match_cnt_q;
  logic [3:0] miss_cnt_q;
  logic [14:0] chk_state_q;
  logic [14:0] gen_state_q;
  logic [10:0] byte_idx_q;
  bist_loop_pkg::gen_state_e gen_fsm_q;
  bist_loop_pkg::byte_beat_s gen_beat_q;
  logic [15:0] err_cnt_q;
  logic [15:0] frm_cnt_q;
  logic wrap_pulse_q;
  logic [3:0] loop_out_q;
  logic fwd_rx_q;
  logic fwd_tx_q;

  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic rd_access;
  logic addr_ctl;
  logic addr_sts;
  logic addr_hit;
  logic [15:0] wr_ctl;
  logic [15:0] sts_word;
  logic wrap_mode;
  logic random_sel;
  logic gen_en;
  logic [10:0] frame_last;
  logic checker_on;
  logic [7:0] expected_byte;
  logic rx_match;
  logic rx_mismatch;
  logic frame_end;
  logic err_event;
  logic err_at_max;
  logic frm_at_max;

  // Bus phase and address decode.
  assign setup_phase = apb_req.psel && !apb_req.penable;
  assign access_phase = apb_req.psel && apb_req.penable;
  assign wr_access = access_phase && apb_req.pwrite && addr_ctl;
  assign rd_access = access_phase && !apb_req.pwrite;

  always_comb begin
    addr_ctl = 1'b0;
    addr_sts = 1'b0;
    if (apb_req.paddr == bist_loop_pkg::ADDR_SELF_TEST_CONTROL) begin
      addr_ctl = 1'b1;
    end else if (apb_req.paddr == bist_loop_pkg::ADDR_SECONDARY_STATUS) begin
      addr_sts = 1'b1;
    end
  end
  assign addr_hit = addr_ctl || addr_sts;

  // Zero-wait answer; read data is a flop loaded during the setup cycle.
  assign apb_rsp.pready = access_phase;
  assign apb_rsp.pslverr = access_phase && !addr_hit;
  assign apb_rsp.prdata = prdata_q;

  assign wrap_mode = ctl_q[bist_loop_pkg::CTL_WRAP_MODE];
  assign random_sel = ctl_q[bist_loop_pkg::CTL_RANDOM_PAYLOAD];
  assign gen_en = ctl_q[bist_loop_pkg::CTL_GEN_ENABLE];

  // New control word: reserved bits dropped, forward bits only in their own loop mode.
  always_comb begin
    wr_ctl = apb_req.pwdata[15:0] & bist_loop_pkg::CTL_WRITABLE_MASK;
    if (wr_ctl[bist_loop_pkg::CTL_LOOP_HI:bist_loop_pkg::CTL_LOOP_LO]
        != bist_loop_pkg::LOOP_REVERSE) begin
      wr_ctl[bist_loop_pkg::CTL_REV_FWD] = 1'b0;
    end
    if (wr_ctl[bist_loop_pkg::CTL_LOOP_HI:bist_loop_pkg::CTL_LOOP_LO]
        != bist_loop_pkg::LOOP_DIGITAL) begin
      wr_ctl[bist_loop_pkg::CTL_MII_FWD] = 1'b0;
    end
  end

  // Control register; a write lands at the access edge.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q <= bist_loop_pkg::CTL_RESET;
    end else if (wr_access) begin
      ctl_q <= wr_ctl;
    end
  end

  // Status word assembled from live state; unused bits stay zero.
  always_comb begin
    sts_word = 16'h0000;
    sts_word[bist_loop_pkg::STS_LOCKED] = locked_q;
    sts_word[bist_loop_pkg::STS_LOCK_DROPPED] = lock_dropped_q;
    sts_word[bist_loop_pkg::STS_GEN_ACTIVE] = (gen_fsm_q == bist_loop_pkg::GEN_SEND);
    sts_word[bist_loop_pkg::STS_LEGACY_MASTER] = legacy_master;
    sts_word[bist_loop_pkg::STS_LEGACY_SLAVE] = legacy_slave;
    sts_word[bist_loop_pkg::STS_CORE_POWER] = core_normal_power;
  end

  // Read data captured in the setup cycle so the access cycle needs no wait state.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_phase && !apb_req.pwrite) begin
      if (addr_ctl) begin
        prdata_q <= {16'h0000, ctl_q};
      end else if (addr_sts) begin
        prdata_q <= {16'h0000, sts_word};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // The checker runs only with random payload selected; constant frames disable it.
  assign checker_on = random_sel;
  assign expected_byte = chk_state_q[7:0];
  assign rx_match = checker_on && rx_beat.valid && (rx_beat.data == expected_byte);
  assign rx_mismatch = checker_on && rx_beat.valid && (rx_beat.data != expected_byte);

  // Checker sequence: re-seeds from the incoming stream while unlocked so it can self-align.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      chk_state_q <= bist_loop_pkg::PRBS_SEED;
    end else if (!checker_on) begin
      chk_state_q <= bist_loop_pkg::PRBS_SEED;
    end else if (rx_beat.valid) begin
      if (rx_mismatch && !locked_q) begin
        // The upper seven bits already hold the low seven bits of the previous received byte.
        chk_state_q <= prbs_step({chk_state_q[14:8], rx_beat.data});
      end else begin
        chk_state_q <= prbs_step(chk_state_q);
      end
    end
  end

  // Lock on a run of matches, drop it on a run of mismatches.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      locked_q <= 1'b0;
      match_cnt_q <= 4'h0;
      miss_cnt_q <= 4'h0;
    end else if (!checker_on) begin
      locked_q <= 1'b0;
      match_cnt_q <= 4'h0;
      miss_cnt_q <= 4'h0;
    end else if (rx_match) begin
      miss_cnt_q <= 4'h0;
      if (!locked_q) begin
        if (match_cnt_q == bist_loop_pkg::LOCK_MATCH_COUNT - 4'h1) begin
          locked_q <= 1'b1;
          match_cnt_q <= 4'h0;
        end else begin
          match_cnt_q <= match_cnt_q + 4'h1;
        end
      end
    end else if (rx_mismatch) begin
      match_cnt_q <= 4'h0;
      if (locked_q) begin
        if (miss_cnt_q == bist_loop_pkg::LOSS_MISMATCH_COUNT - 4'h1) begin
          locked_q <= 1'b0;
          miss_cnt_q <= 4'h0;
        end else begin
          miss_cnt_q <= miss_cnt_q + 4'h1;
        end
      end
    end
  end

  // Lock-dropped flag: a new drop wins over the clearing read, and only a reported one clears.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_dropped_q <= 1'b0;
    end else if (locked_q && !checker_on || locked_q && rx_mismatch &&
                 miss_cnt_q == bist_loop_pkg::LOSS_MISMATCH_COUNT - 4'h1) begin
      lock_dropped_q <= 1'b1;
    end else if (rd_access && addr_sts && prdata_q[bist_loop_pkg::STS_LOCK_DROPPED]) begin
      lock_dropped_q <= 1'b0;
    end
  end

  assign frame_last = ctl_q[bist_loop_pkg::CTL_SHORT_FRAME] ?
                      bist_loop_pkg::SHORT_FRAME_BYTES - 11'd1 :
                      bist_loop_pkg::LONG_FRAME_BYTES - 11'd1;
  assign frame_end = (gen_fsm_q == bist_loop_pkg::GEN_SEND) && (byte_idx_q == frame_last);

  // Generator sequencer: back-to-back frames for random payload, a single frame otherwise.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gen_fsm_q <= bist_loop_pkg::GEN_IDLE;
      byte_idx_q <= 11'd0;
    end else begin
      case (gen_fsm_q)
        bist_loop_pkg::GEN_IDLE: begin
          byte_idx_q <= 11'd0;
          if (gen_en) begin
            gen_fsm_q <= bist_loop_pkg::GEN_SEND;
          end
        end
        bist_loop_pkg::GEN_SEND: begin
          if (!gen_en) begin
            gen_fsm_q <= bist_loop_pkg::GEN_IDLE;
            byte_idx_q <= 11'd0;
          end else if (frame_end) begin
            byte_idx_q <= 11'd0;
            if (!random_sel) begin
              gen_fsm_q <= bist_loop_pkg::GEN_DONE;
            end
          end else begin
            byte_idx_q <= byte_idx_q + 11'd1;
          end
        end
        bist_loop_pkg::GEN_DONE: begin
          // A fresh single frame needs the enable to be cleared and set again.
          if (!gen_en) begin
            gen_fsm_q <= bist_loop_pkg::GEN_IDLE;
          end
        end
        default: begin
          gen_fsm_q <= bist_loop_pkg::GEN_IDLE;
        end
      endcase
    end
  end

  // Generator sequence advances one byte per beat and is held at the seed in constant mode.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gen_state_q <= bist_loop_pkg::PRBS_SEED;
    end else if (!random_sel) begin
      gen_state_q <= bist_loop_pkg::PRBS_SEED;
    end else if (gen_fsm_q == bist_loop_pkg::GEN_SEND && gen_en) begin
      gen_state_q <= prbs_step(gen_state_q);
    end
  end

  // Registered output beat with frame delimiters.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gen_beat_q <= '0;
    end else begin
      gen_beat_q.valid <= (gen_fsm_q == bist_loop_pkg::GEN_SEND) && gen_en;
      gen_beat_q.first <= (gen_fsm_q == bist_loop_pkg::GEN_SEND) && (byte_idx_q == 11'd0);
      gen_beat_q.last <= frame_end;
      gen_beat_q.data <= random_sel ? gen_state_q[7:0] : bist_loop_pkg::CONSTANT_BYTE;
    end
  end
  assign gen_beat = gen_beat_q;

  assign err_event = rx_mismatch && locked_q;
  assign err_at_max = err_event && (err_cnt_q == bist_loop_pkg::COUNTER_MAX);
  assign frm_at_max = frame_end && gen_en && (frm_cnt_q == bist_loop_pkg::COUNTER_MAX);

  // Error and frame counters; without wrap mode they saturate, which is unsupported use.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      err_cnt_q <= 16'h0000;
      frm_cnt_q <= 16'h0000;
    end else begin
      if (err_event) begin
        err_cnt_q <= count_step(err_cnt_q, wrap_mode);
      end
      if (frame_end && gen_en) begin
        frm_cnt_q <= count_step(frm_cnt_q, wrap_mode);
      end
    end
  end

  // One pulse per cycle in which either or both counters wrap.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrap_pulse_q <= 1'b0;
    end else begin
      wrap_pulse_q <= wrap_mode && (err_at_max || frm_at_max);
    end
  end
  assign counter_wrap_pulse = wrap_pulse_q;
  assign error_count = err_cnt_q;
  assign frame_count = frm_cnt_q;

  // Loop point outputs; the coding field is interpreted per line rate.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      loop_out_q <= 4'h0;
      fwd_rx_q <= 1'b1;
      fwd_tx_q <= 1'b1;
    end else begin
      loop_out_q[0] <= speed_100 &&
        ctl_q[bist_loop_pkg::CTL_CODING_HI:bist_loop_pkg::CTL_CODING_LO]
        == bist_loop_pkg::CODING_AFTER_ENCODER;
      loop_out_q[1] <= speed_100 &&
        ctl_q[bist_loop_pkg::CTL_CODING_HI:bist_loop_pkg::CTL_CODING_LO]
        == bist_loop_pkg::CODING_AFTER_SCRAMBLER;
      loop_out_q[2] <= speed_100 &&
        ctl_q[bist_loop_pkg::CTL_CODING_HI:bist_loop_pkg::CTL_CODING_LO]
        == bist_loop_pkg::CODING_BEFORE_SCRAMBLER;
      loop_out_q[3] <= speed_1000 && ctl_q[bist_loop_pkg::CTL_CODING_LO];
      // Receive to MAC is withheld in reverse loop unless forwarding is asked for.
      fwd_rx_q <= (ctl_q[bist_loop_pkg::CTL_LOOP_HI:bist_loop_pkg::CTL_LOOP_LO]
                   != bist_loop_pkg::LOOP_REVERSE) || ctl_q[bist_loop_pkg::CTL_REV_FWD];
      // Transmit to the line is suppressed in MII loop unless forwarding is asked for.
      fwd_tx_q <= (ctl_q[bist_loop_pkg::CTL_LOOP_HI:bist_loop_pkg::CTL_LOOP_LO]
                   != bist_loop_pkg::LOOP_DIGITAL) || ctl_q[bist_loop_pkg::CTL_MII_FWD];
    end
  end

  // The one-hot field goes out as written; any other pattern selects no loop.
  always_comb begin
    case (ctl_q[bist_loop_pkg::CTL_LOOP_HI:bist_loop_pkg::CTL_LOOP_LO])
      bist_loop_pkg::LOOP_REVERSE,
      bist_loop_pkg::LOOP_EXTERNAL,
      bist_loop_pkg::LOOP_ANALOG,
      bist_loop_pkg::LOOP_DIGITAL: begin
        loop_select = ctl_q[bist_loop_pkg::CTL_LOOP_HI:bist_loop_pkg::CTL_LOOP_LO];
      end
      default: begin
        loop_select = 4'h0;
      end
    endcase
  end

  assign coding_after_encoder = loop_out_q[0];
  assign coding_after_scrambler = loop_out_q[1];
  assign coding_before_scrambler = loop_out_q[2];
  assign gig_loop_before_dsp = loop_out_q[3];
  assign rx_to_mac_enable = fwd_rx_q;
  assign tx_to_line_enable = fwd_tx_q;

endmodule // phy_bist_loopback_control

// ==== tb/bist_loop_checker.sv ====
// Port-level assertions for the self-test and loopback control block.
`timescale 1ns/100ps
module bist_loop_checker (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire bist_loop_pkg::apb_req_s apb_req,
  input wire bist_loop_pkg::apb_rsp_s apb_rsp,
  input wire bist_loop_pkg::byte_beat_s gen_beat,
  input wire logic speed_100,
  input wire logic speed_1000,
  input wire logic [3:0] loop_select,
  input wire logic coding_after_encoder,
  input wire logic coding_after_scrambler,
  input wire logic coding_before_scrambler,
  input wire logic gig_loop_before_dsp,
  input wire logic rx_to_mac_enable,
  input wire logic tx_to_line_enable,
  input wire logic counter_wrap_pulse
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  logic [10:0] len_q;
  logic [31:0] zero_mask;
  logic [2:0] coding;
  // Bytes of the frame in flight; a first byte restarts the count.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      len_q <= 11'h000;
    end else if (gen_beat.valid) begin
      len_q <= gen_beat.first ? 11'h001 : len_q + 11'h001;
    end
  end
  // Bits that must read zero; an unmapped address returns no data at all.
  assign zero_mask = (apb_req.paddr == bist_loop_pkg::ADDR_SELF_TEST_CONTROL) ? 32'hFFFF0F00 :
      (apb_req.paddr == bist_loop_pkg::ADDR_SECONDARY_STATUS) ? 32'hFFFFF03F : 32'hFFFFFFFF;
  assign coding = {coding_after_encoder, coding_after_scrambler, coding_before_scrambler};
  sequence frame_end;
    gen_beat.valid && gen_beat.last;
  endsequence
  sequence read_access;
    apb_req.psel && apb_req.penable && !apb_req.pwrite;
  endsequence
  chk_frame_length: assert property (frame_end |-> len_q == 11'h03F || len_q == 11'h5ED)
    else $error("generated frame has a wrong length");
  chk_reserved_zero: assert property (read_access |-> ~|(apb_rsp.prdata & zero_mask))
    else $error("reserved bits read nonzero");
  chk_mac_gate: assert property (!rx_to_mac_enable |-> $past(loop_select) == 4'h8)
    else $error("receive path gated outside reverse loop");
  chk_line_gate: assert property (!tx_to_line_enable |-> $past(loop_select) == 4'h1)
    else $error("transmit path gated outside digital loop");
  chk_loop_onehot: assert property ($onehot0(loop_select))
    else $error("loopback select is not one-hot");
  chk_coding_rate: assert property (|coding |-> $past(speed_100) && $onehot0(coding))
    else $error("coding loop point without 100 Mb/s");
  chk_gig_loop: assert property (gig_loop_before_dsp |-> $past(speed_1000))
    else $error("gigabit loop without 1000 Mb/s");
  chk_wrap_single: assert property (counter_wrap_pulse |=> !counter_wrap_pulse)
    else $error("wrap pulse longer than one cycle");
endmodule // bist_loop_checker

bind phy_bist_loopback_control bist_loop_checker u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .gen_beat(gen_beat), .speed_100(speed_100),
  .speed_1000(speed_1000), .loop_select(loop_select), .coding_after_encoder(coding_after_encoder),
  .coding_after_scrambler(coding_after_scrambler),
  .coding_before_scrambler(coding_before_scrambler),
  .gig_loop_before_dsp(gig_loop_before_dsp), .rx_to_mac_enable(rx_to_mac_enable),
  .tx_to_line_enable(tx_to_line_enable), .counter_wrap_pulse(counter_wrap_pulse));

// ==== tb/bist_link_partner.sv ====
// Link partner model that loops the generated stream back into the receive side.
`timescale 1ns/100ps
module bist_link_partner (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire bist_loop_pkg::byte_beat_s gen_beat,
  input wire logic corrupt,
  output bist_loop_pkg::byte_beat_s rx_beat
);
  // One cycle of line delay; bytes are inverted only while the bench asks for it.
  // Between frames the data toggles so a stale byte can never pass for a match.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_beat <= '0;
    end else begin
      rx_beat.valid <= gen_beat.valid;
      rx_beat.first <= gen_beat.first;
      rx_beat.last <= gen_beat.last;
      rx_beat.data <= gen_beat.valid ? gen_beat.data ^ {8{corrupt}} : ~rx_beat.data;
    end
  end
endmodule // bist_link_partner

// ==== tb/phy_bist_loopback_control_tb.sv ====
// Self-checking bench for the self-test and loopback control block.
`timescale 1ns/100ps
module phy_bist_loopback_control_tb;
  localparam logic [11:0] CTL = bist_loop_pkg::ADDR_SELF_TEST_CONTROL;
  localparam logic [11:0] STS = bist_loop_pkg::ADDR_SECONDARY_STATUS;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  bist_loop_pkg::apb_req_s apb_req = '0;
  bist_loop_pkg::apb_rsp_s apb_rsp;
  bist_loop_pkg::byte_beat_s rx_beat;
  bist_loop_pkg::byte_beat_s gen_beat;
  logic speed_100 = 1'b1;
  logic speed_1000 = 1'b0;
  logic legacy_master = 1'b1;
  logic legacy_slave = 1'b0;
  logic core_normal_power = 1'b1;
  logic corrupt = 1'b0;
  logic [3:0] loop_select;
  logic enc, scr, pre, gig, rx_en, tx_en;
  logic wrap;
  logic [15:0] err_count;
  logic [15:0] frm_count;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int n_checks = 0;
  int nbytes, nframes, nbad, ngap;

  always #2 ref_clk = ~ref_clk;

  phy_bist_loopback_control dut (.ref_clk(ref_clk), .rst_b(rst_b), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .rx_beat(rx_beat), .gen_beat(gen_beat), .speed_100(speed_100),
    .speed_1000(speed_1000), .legacy_master(legacy_master), .legacy_slave(legacy_slave),
    .core_normal_power(core_normal_power), .loop_select(loop_select),
    .coding_after_encoder(enc), .coding_after_scrambler(scr), .coding_before_scrambler(pre),
    .gig_loop_before_dsp(gig), .rx_to_mac_enable(rx_en), .tx_to_line_enable(tx_en),
    .counter_wrap_pulse(wrap), .error_count(err_count), .frame_count(frm_count));

  bist_link_partner partner (.ref_clk(ref_clk), .rst_b(rst_b), .gen_beat(gen_beat),
    .corrupt(corrupt), .rx_beat(rx_beat));

  // Byte, frame and idle-gap counts of the generated stream; scenarios clear them.
  always @(posedge ref_clk) begin
    if (gen_beat.valid) begin
      nbytes++;
      nframes += gen_beat.last;
      nbad += (gen_beat.data !== 8'h55);
    end else if (nbytes != 0) begin
      ngap++;
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One APB transfer; the request holds until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [15:0] wdata);
    int n;
    @(posedge ref_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: {16'h0000, wdata}};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (apb_rsp.pready === 1'b1) break;
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    if (n == 50) begin
      mismatches++;
      complete_run();
    end
  endtask

  // Waiting is bounded, so a stalled generator ends the run instead of hanging it.
  task automatic wait_frames(input int want);
    for (int n = 0; n < 4000 && nframes < want; n++) @(posedge ref_clk);
    if (nframes < want) begin
      mismatches++;
      complete_run();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic sc_regs();
    apb(1'b0, CTL, 16'h0000);
    check("control reset", 32'h0, rd);
    apb(1'b0, STS, 16'h0000);
    check("status", 32'h0140, rd);
    legacy_master <= 1'b0;
    legacy_slave <= 1'b1;
    core_normal_power <= 1'b0;
    apb(1'b1, CTL, 16'h0FC0);
    apb(1'b1, STS, 16'hFFFF);
    apb(1'b0, CTL, 16'h0000);
    check("control reserved", 32'h0, rd);
    apb(1'b0, STS, 16'h0000);
    check("status", 32'h0080, rd);
    apb(1'b0, 12'h060, 16'h0000);
    check("unmapped error", 32'h1, err);
  endtask

  task automatic sc_loops();
    logic [3:0] code;
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 4; i++) begin
        code = 4'h1 << i;
        apb(1'b1, CTL, {8'h00, j ? 2'b00 : 2'b11, code, 2'b00});
        cyc(2);
        check("loop select", code, loop_select);
        check("mac gate", !(code == 4'h8 && j), rx_en);
        check("line gate", !(code == 4'h1 && j), tx_en);
        apb(1'b0, CTL, 16'h0000);
        check("forward bits", {code[3] && !j, code[0] && !j, code, 2'b00}, rd);
      end
    end
  endtask

  task automatic sc_coding();
    for (int s = 0; s < 2; s++) begin
      speed_100 <= !s;
      speed_1000 <= 1'(s);
      for (int c = 1; c < 4; c++) begin
        apb(1'b1, CTL, 16'(c));
        cyc(2);
        check("coding point", s ? 3'b000 : 3'b100 >> (3 - c), {enc, scr, pre});
        check("gigabit loop", s & c, gig);
      end
    end
  endtask

  task automatic sc_const();
    for (int s = 1; s >= 0; s--) begin
      nbytes = 0;
      nframes = 0;
      nbad = 0;
      apb(1'b1, CTL, {2'b10, 1'(s), 1'b1, 12'h000});
      cyc(10);
      apb(1'b0, STS, 16'h0000);
      check("busy", 32'h1, rd[9]);
      wait_frames(1);
      cyc(40);
      check("frame bytes", s ? 64 : 1518, nbytes);
      check("single frame", 32'h1, nframes);
      check("constant data", 32'h0, nbad);
      apb(1'b0, STS, 16'h0000);
      check("idle and unlocked", 32'h0, {rd[11], rd[9]});
      apb(1'b1, CTL, 16'h0000);
    end
    check("frame count", 32'h2, frm_count);
  endtask

  task automatic sc_random();
    int seen;
    nbytes = 0;
    nframes = 0;
    ngap = 0;
    apb(1'b1, CTL, 16'hF000);
    wait_frames(4);
    check("gap cycles", 32'h0, ngap);
    apb(1'b0, STS, 16'h0000);
    check("locked", 32'h1, rd[11]);
    @(posedge ref_clk);
    corrupt <= 1'b1;
    repeat (8) @(posedge ref_clk);
    corrupt <= 1'b0;
    cyc(60);
    apb(1'b0, STS, 16'h0000);
    check("lock dropped", 32'h1, rd[10]);
    check("error count", {28'h0, bist_loop_pkg::LOSS_MISMATCH_COUNT}, err_count);
    apb(1'b0, STS, 16'h0000);
    check("drop cleared, relocked", 32'h2, {rd[11], rd[10]});
    apb(1'b1, CTL, 16'hC000);
    cyc(10);
    seen = nbytes;
    cyc(50);
    check("generator stopped", seen, nbytes);
    apb(1'b0, STS, 16'h0000);
    check("checker kept", 32'h2, {rd[11], rd[10]});
    apb(1'b1, CTL, 16'h8000);
    apb(1'b0, STS, 16'h0000);
    check("lock after random off", 32'h1, {rd[11], rd[10]});
    check("wrap pulse", 32'h0, wrap);
  endtask

  // Reset for six cycles, then the scenarios in turn.
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    sc_regs();
    sc_loops();
    sc_coding();
    sc_const();
    sc_random();
    complete_run();
  end
endmodule // phy_bist_loopback_control_tb
